/* File: logic/fbm_pkg.sv */
// constants and helpers shared by both ends of the buffer manager
// Notes on behaviour
// RL1: hand free handles to dma or management frames
// RL2: finished frame's handle goes back to pool
// RL3: pool empty at reset; filled via indirect group
// RL4: software writes handles 0 to K-1 singly
// RL5: no free handle means frame refused
// RL6: per-port counts; over threshold drops frames
// RL7: multicast buffer count capped by limit register
// RL8: sram 64K or 128K words, one/two banks
// RL9: data blocks of 1.5KB, count from register
// RL10: frame data region starts at address zero
// RL11: one to four priorities, 12 to 48 queues
// RL12: queue holds 128 to 1024 entries
// RL13: queue entry is word holding buffer handle
// RL14: mail entry 32 or 64 bytes, fixed
// RL15: hardware keeps free and pending mail pointers
// RL16: vlan table 4K by 8 bytes, register base
// RL17: vlan table on 32KB boundary
// RL18: vlan-mac table 2048 entries, 16-64KB
// RL19: two-bit size field plus base field
// RL20: vlan-mac table on 16KB boundary
// RL21: managed mode has five memory regions
// RL22: unmanaged mode has no vlan tables
// RL23: refused frame consumes no handle
// RL24: counters follow allocation and release
`default_nettype none
package fbm_pkg;
   localparam int NPORTS = 12;
   localparam int HW = 10;
   localparam int MAX_BUFS = 1024;
   localparam int CW = 11;
   localparam int DW = 32;
   localparam int RW = 4;
   localparam int AW = 24;
   localparam int MAIL_ENTRIES = 128;
   // ==========================================
   // device register indices
   localparam logic [RW-1:0] REG_CMD = 4'h0;
   localparam logic [RW-1:0] REG_DATA = 4'h1;
   localparam logic [RW-1:0] REG_READY = 4'h2;
   localparam logic [RW-1:0] REG_THR_A = 4'h3;
   localparam logic [RW-1:0] REG_THR_B = 4'h4;
   localparam logic [RW-1:0] REG_MC_LIMIT = 4'h5;
   localparam logic [RW-1:0] REG_BUF_COUNT = 4'h6;
   localparam logic [RW-1:0] REG_VLAN_BASE = 4'h7;
   localparam logic [RW-1:0] REG_MEM_CFG = 4'h8;
   localparam logic [RW-1:0] REG_FREE_MAIL = 4'h9;
   localparam logic [RW-1:0] REG_PEND_MAIL = 4'hA;
   localparam logic [RW-1:0] REG_STATUS = 4'hB;
   // ==========================================
   // field positions
   localparam int CMD_TYPE_LSB = 0;
   localparam int CMD_WRITE_BIT = 4;
   localparam logic [3:0] TYPE_FREE_TABLE = 4'h1;
   localparam int VLAN_FLD_LSB = 0;
   localparam int VMAC_FLD_LSB = 8;
   localparam int VMAC_SEL_LSB = 16;
   localparam int CFG_BIG_SRAM = 0;
   localparam int CFG_TWO_BANKS = 1;
   localparam int CFG_PRIO_LSB = 2;
   localparam int CFG_QSIZE_LSB = 4;
   localparam int CFG_MAIL64 = 6;
   localparam int CFG_MANAGED = 7;
   localparam int MAIL_VALID_BIT = 31;
   localparam int ST_MC_LSB = 16;
   localparam int ST_ERR_BIT = 31;
   // ==========================================
   // memory layout
   localparam logic [AW-1:0] FDB_BLOCK_BYTES = 24'h00_0600;
   localparam logic [AW-1:0] FDB_BASE = 24'h00_0000;
   localparam logic [AW-1:0] TXQ_ENTRY_BYTES = 24'h00_0004;
   localparam logic [AW-1:0] TXQ_MIN_ENTRIES = 24'h00_0080;
   localparam logic [AW-1:0] MEM_HALF_MB = 24'h08_0000;
   localparam logic [AW-1:0] VLAN_TABLE_BYTES = 24'h00_8000;
   localparam logic [AW-1:0] VMAC_MIN_BYTES = 24'h00_4000;
   localparam logic [AW-1:0] MAIL_SMALL_BYTES = 24'h00_0020;
   localparam logic [AW-1:0] MAIL_LARGE_BYTES = 24'h00_0040;
   localparam int VLAN_ALIGN_SHIFT = 15;
   localparam int VMAC_ALIGN_SHIFT = 14;
   localparam logic [1:0] VMAC_SEL_BAD = 2'h3;
   localparam logic [4:0] SRAM_MSB_MIN = 5'h12;
   // ==========================================
   // controller register indices (word index of wishbone address)
   localparam logic [4:0] WB_FILL = 5'h10;
   localparam logic [4:0] WB_STAT = 5'h11;

   function automatic logic [CW-1:0] cnt_step(input logic [CW-1:0] c,
                                              input logic inc,
                                              input logic dec);
      cnt_step = c + CW'(inc) - CW'(dec);
   endfunction

   function automatic logic [AW-1:0] fdb_addr(input logic [HW-1:0] h);
      fdb_addr = FDB_BASE + AW'(h) * FDB_BLOCK_BYTES;
   endfunction
endpackage
`default_nettype wire

/* File: logic/fbm_if.sv */
// register link between controller and buffer manager
`default_nettype none
interface fbm_if;
   logic req;
   logic we;
   logic [fbm_pkg::RW-1:0] addr;
   logic [fbm_pkg::DW-1:0] wdata;
   logic [fbm_pkg::DW-1:0] rdata;
   logic ack;
   modport dev (input req, input we, input addr, input wdata,
                output rdata, output ack);
   modport ctl (output req, output we, output addr, output wdata,
                input rdata, input ack);
endinterface
`default_nettype wire

/* File: logic/fbm_dev.sv */
// buffer manager: handle pool, buffer counters, memory layout, mail
//
// Register access over Wishbone and the register offsets were left to the implementer.
`default_nettype none
module fbm_dev (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic CE,
   fbm_if.dev LINK,
   input wire logic [1:0] RX_REQ,
   input wire logic [1:0][3:0] RX_PORT,
   input wire logic [1:0] RX_MCAST,
   output logic [1:0] RX_ACK,
   output logic RX_DROP,
   output logic [fbm_pkg::HW-1:0] ALLOC_HANDLE,
   output logic [fbm_pkg::AW-1:0] ALLOC_ADDR,
   input wire logic REL_VALID,
   input wire logic [fbm_pkg::HW-1:0] REL_HANDLE,
   output logic [fbm_pkg::NPORTS-1:0] PORT_BLOCKED,
   input wire logic [5:0] TXQ_SEL,
   input wire logic [9:0] TXQ_IDX,
   output logic [fbm_pkg::AW-1:0] TXQ_ADDR,
   output logic [fbm_pkg::DW-1:0] TXQ_WORD,
   output logic [fbm_pkg::AW-1:0] TXQ_BASE,
   output logic [fbm_pkg::AW-1:0] MAIL_BASE,
   output logic [fbm_pkg::AW-1:0] VLAN_BASE,
   output logic [fbm_pkg::AW-1:0] VMAC_BASE,
   output logic [fbm_pkg::AW-1:0] VMAC_BYTES,
   output logic VLAN_EN,
   output logic [4:0] SRAM_ADDR_MSB,
   output logic LAYOUT_ERR
);
   import fbm_pkg::*;

   // ==========================================
   // registers
   logic ack_ff;
   logic [DW-1:0] rdata_ff;
   logic [DW-1:0] data_ff;
   logic pend_ff;
   logic [CW-1:0] thr_a_ff, thr_b_ff, mc_lim_ff;
   logic [HW-1:0] buf_cnt_ff;
   logic [DW-1:0] vbase_ff;
   logic [7:0] cfg_ff;
   logic [1:0] rx_ack_ff;
   logic rx_drop_ff;
   logic [HW-1:0] handle_ff;
   logic [AW-1:0] aaddr_ff;

   logic take_reg, wr_reg;
   assign take_reg = LINK.req && !ack_ff;
   assign wr_reg = take_reg && LINK.we;
   assign LINK.ack = ack_ff;
   assign LINK.rdata = rdata_ff;

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         data_ff <= '0;
         thr_a_ff <= '0;
         thr_b_ff <= '0;
         mc_lim_ff <= '0;
         buf_cnt_ff <= '0;
         vbase_ff <= '0;
         cfg_ff <= '0;
      end else if (CE && wr_reg) begin
         case (LINK.addr)
            REG_DATA: data_ff <= LINK.wdata;
            REG_THR_A: thr_a_ff <= LINK.wdata[CW-1:0]; // RL6
            REG_THR_B: thr_b_ff <= LINK.wdata[CW-1:0]; // RL6
            REG_MC_LIMIT: mc_lim_ff <= LINK.wdata[CW-1:0]; // RL7
            REG_BUF_COUNT: buf_cnt_ff <= LINK.wdata[HW-1:0]; // RL9
            REG_VLAN_BASE: vbase_ff <= LINK.wdata; // RL19
            REG_MEM_CFG: cfg_ff <= LINK.wdata[7:0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // free handle pool
   logic [HW-1:0] pool_mem [MAX_BUFS];
   logic [HW-1:0] rd_ff, wr_ff;
   logic [CW-1:0] free_ff;
   logic init_push, push, grant, take, win, mc, refuse;
   logic [3:0] port;
   logic [HW-1:0] push_val, head;
   logic [CW-1:0] mc_cnt_ff;
   logic [NPORTS-1:0][CW-1:0] pcnt_ff;
   logic [NPORTS-1:0] blk_ff;

   // a release owns the write port; table writes wait while REL_VALID is high
   assign init_push = pend_ff && !REL_VALID; // RL3
   assign push = REL_VALID || init_push; // RL2
   assign push_val = REL_VALID ? REL_HANDLE : data_ff[HW-1:0];
   assign head = pool_mem[rd_ff];

   assign take = (RX_REQ[0] && !rx_ack_ff[0]) || (RX_REQ[1] && !rx_ack_ff[1]);
   assign win = !(RX_REQ[0] && !rx_ack_ff[0]);
   assign port = RX_PORT[win];
   assign mc = RX_MCAST[win];
   always_comb begin
      refuse = (free_ff == '0); // RL5
      if (mc) begin
         refuse = refuse || (mc_cnt_ff >= mc_lim_ff); // RL7
      end else if (int'(port) >= NPORTS) begin
         refuse = 1'b1;
      end else begin
         refuse = refuse || blk_ff[port]; // RL6
      end
   end
   assign grant = take && !refuse; // RL23

   always_ff @(posedge MCLK) begin
      if (CE && push) begin
         pool_mem[wr_ff] <= push_val;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rd_ff <= '0;
         wr_ff <= '0;
         free_ff <= '0; // RL3
      end else if (CE) begin
         rd_ff <= rd_ff + HW'(grant);
         wr_ff <= wr_ff + HW'(push);
         free_ff <= cnt_step(free_ff, push, grant);
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pend_ff <= 1'b0;
      end else if (CE) begin
         if (wr_reg && LINK.addr == REG_CMD && LINK.wdata[CMD_WRITE_BIT]
             && LINK.wdata[CMD_TYPE_LSB+:4] == TYPE_FREE_TABLE) begin
            pend_ff <= 1'b1; // RL3
         end else if (init_push) begin
            pend_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rx_ack_ff <= '0;
         rx_drop_ff <= 1'b0;
         handle_ff <= '0;
         aaddr_ff <= '0;
      end else if (CE) begin
         rx_ack_ff <= {take && win, take && !win};
         if (take) begin
            rx_drop_ff <= refuse; // RL23
            handle_ff <= refuse ? '0 : head; // RL1
            aaddr_ff <= refuse ? '0 : fdb_addr(head);
         end
      end
   end
   assign RX_ACK = rx_ack_ff;
   assign RX_DROP = rx_drop_ff;
   assign ALLOC_HANDLE = handle_ff;
   assign ALLOC_ADDR = aaddr_ff;

   // ==========================================
   // per-handle owner record and buffer counters
   logic [3:0] own_port [MAX_BUFS];
   logic own_mc [MAX_BUFS];
   logic [3:0] rel_port;
   logic rel_mc;
   assign rel_port = own_port[REL_HANDLE];
   assign rel_mc = own_mc[REL_HANDLE];

   always_ff @(posedge MCLK) begin
      if (CE && grant) begin
         own_port[head] <= port;
         own_mc[head] <= mc;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mc_cnt_ff <= '0;
         pcnt_ff <= '0;
         blk_ff <= '0;
      end else if (CE) begin
         mc_cnt_ff <= cnt_step(mc_cnt_ff, grant && mc,
                               REL_VALID && rel_mc); // RL24
         for (int p = 0; p < NPORTS; p++) begin
            pcnt_ff[p] <= cnt_step(pcnt_ff[p],
               grant && !mc && int'(port) == p,
               REL_VALID && !rel_mc && int'(rel_port) == p); // RL24
            // hysteresis: block above a, unblock below b
            if (pcnt_ff[p] > thr_a_ff) begin
               blk_ff[p] <= 1'b1; // RL6
            end else if (pcnt_ff[p] < thr_b_ff) begin
               blk_ff[p] <= 1'b0;
            end
         end
      end
   end
   assign PORT_BLOCKED = blk_ff;

   // ==========================================
   // memory layout
   logic [AW-1:0] mem_b, fdb_end, txq_b, txq_len, qent, mail_b, mail_end;
   logic [AW-1:0] vl_b, vm_b, vm_len, msize;
   logic [5:0] nq;
   logic managed, err;
   logic [1:0] vsel;
   always_comb begin
      managed = cfg_ff[CFG_MANAGED];
      mem_b = MEM_HALF_MB << (32'(cfg_ff[CFG_BIG_SRAM])
                + 32'(cfg_ff[CFG_TWO_BANKS])); // RL8
      fdb_end = fdb_addr(buf_cnt_ff); // RL9 RL10
      nq = 6'(NPORTS) * (6'(cfg_ff[CFG_PRIO_LSB+:2]) + 6'h1); // RL11
      qent = TXQ_MIN_ENTRIES << cfg_ff[CFG_QSIZE_LSB+:2]; // RL12
      txq_len = AW'(nq) * qent * TXQ_ENTRY_BYTES; // RL13
      txq_b = fdb_end;
      msize = cfg_ff[CFG_MAIL64] ? MAIL_LARGE_BYTES : MAIL_SMALL_BYTES; // RL14
      mail_b = txq_b + txq_len;
      mail_end = mail_b + AW'(MAIL_ENTRIES) * msize;
      // bases kept in aligned units so misalignment cannot occur
      vl_b = AW'(vbase_ff[VLAN_FLD_LSB+:6]) << VLAN_ALIGN_SHIFT; // RL16 RL17
      vm_b = AW'(vbase_ff[VMAC_FLD_LSB+:7]) << VMAC_ALIGN_SHIFT; // RL20
      vsel = vbase_ff[VMAC_SEL_LSB+:2];
      vm_len = VMAC_MIN_BYTES << vsel; // RL18 RL19
      err = (mail_end > mem_b) || (int'(buf_cnt_ff) > MAX_BUFS);
      if (managed) begin // RL21
         err = err || (vsel == VMAC_SEL_BAD) || (vl_b < mail_end)
               || (vm_b < mail_end) || (vl_b + VLAN_TABLE_BYTES > mem_b)
               || (vm_b + vm_len > mem_b)
               || ((vl_b < vm_b + vm_len)
                   && (vm_b < vl_b + VLAN_TABLE_BYTES));
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         TXQ_BASE <= '0;
         MAIL_BASE <= '0;
         VLAN_BASE <= '0;
         VMAC_BASE <= '0;
         VMAC_BYTES <= '0;
         VLAN_EN <= 1'b0;
         SRAM_ADDR_MSB <= SRAM_MSB_MIN;
         LAYOUT_ERR <= 1'b0;
         TXQ_ADDR <= '0;
         TXQ_WORD <= '0;
      end else if (CE) begin
         TXQ_BASE <= txq_b;
         MAIL_BASE <= mail_b;
         VLAN_BASE <= managed ? vl_b : '0; // RL22
         VMAC_BASE <= managed ? vm_b : '0; // RL22
         VMAC_BYTES <= managed ? vm_len : '0;
         VLAN_EN <= managed;
         SRAM_ADDR_MSB <= SRAM_MSB_MIN + 5'(cfg_ff[CFG_BIG_SRAM])
                          + 5'(cfg_ff[CFG_TWO_BANKS]); // RL8
         LAYOUT_ERR <= err;
         TXQ_ADDR <= txq_b + (AW'(TXQ_SEL) * qent + AW'(TXQ_IDX))
                     * TXQ_ENTRY_BYTES; // RL13
         TXQ_WORD <= DW'(handle_ff); // RL13
      end
   end

   // ==========================================
   // mail ring: reading the free pointer posts, pending pointer consumes
   logic [HW-1:0] m_wr_ff, m_rd_ff;
   logic [CW-1:0] m_cnt_ff;
   logic rd_free, rd_pend, ok_free, ok_pend;
   assign rd_free = take_reg && !LINK.we && LINK.addr == REG_FREE_MAIL;
   assign rd_pend = take_reg && !LINK.we && LINK.addr == REG_PEND_MAIL;
   assign ok_free = int'(m_cnt_ff) < MAIL_ENTRIES;
   assign ok_pend = m_cnt_ff != '0;

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         m_wr_ff <= '0;
         m_rd_ff <= '0;
         m_cnt_ff <= '0;
      end else if (CE) begin
         if (rd_free && ok_free) begin
            m_wr_ff <= (int'(m_wr_ff) == MAIL_ENTRIES - 1) ? '0
                       : m_wr_ff + 1'b1; // RL15
         end
         if (rd_pend && ok_pend) begin
            m_rd_ff <= (int'(m_rd_ff) == MAIL_ENTRIES - 1) ? '0
                       : m_rd_ff + 1'b1; // RL15
         end
         m_cnt_ff <= cnt_step(m_cnt_ff, rd_free && ok_free,
                              rd_pend && ok_pend);
      end
   end

   // ==========================================
   // read-back and acknowledge
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_ff <= 1'b0;
         rdata_ff <= '0;
      end else if (CE) begin
         ack_ff <= take_reg;
         if (take_reg && !LINK.we) begin
            case (LINK.addr)
               REG_CMD: rdata_ff <= '0;
               REG_DATA: rdata_ff <= data_ff;
               REG_READY: rdata_ff <= DW'(!pend_ff); // RL3
               REG_THR_A: rdata_ff <= DW'(thr_a_ff);
               REG_THR_B: rdata_ff <= DW'(thr_b_ff);
               REG_MC_LIMIT: rdata_ff <= DW'(mc_lim_ff);
               REG_BUF_COUNT: rdata_ff <= DW'(buf_cnt_ff);
               REG_VLAN_BASE: rdata_ff <= vbase_ff;
               REG_MEM_CFG: rdata_ff <= DW'(cfg_ff);
               REG_FREE_MAIL: rdata_ff <= ok_free ? (DW'(mail_b
                  + AW'(m_wr_ff) * msize) | (32'h1 << MAIL_VALID_BIT))
                  : '0; // RL15
               REG_PEND_MAIL: rdata_ff <= ok_pend ? (DW'(mail_b
                  + AW'(m_rd_ff) * msize) | (32'h1 << MAIL_VALID_BIT))
                  : '0; // RL15
               REG_STATUS: rdata_ff <= DW'(free_ff)
                  | (DW'(mc_cnt_ff) << ST_MC_LSB)
                  | (DW'(err) << ST_ERR_BIT);
               default: rdata_ff <= '0;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: logic/fbm_ctl.sv */
// controller end: wishbone slave that drives the buffer manager link
`default_nettype none
module fbm_ctl (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic CE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   fbm_if.ctl LINK
);
   import fbm_pkg::*;

   typedef enum {ST_IDLE, ST_FWD, ST_FILL_DAT, ST_FILL_CMD,
                 ST_FILL_RDY} fbm_state_t;
   fbm_state_t state_ff;
   logic req_ff, we_ff, ack_ff;
   logic [RW-1:0] addr_ff;
   logic [DW-1:0] wdata_ff, dat_ff;
   logic [CW-1:0] fill_k_ff, fill_n_ff;
   logic [4:0] idx;
   logic wb_take, dev_sel, own_take, fwd_take, fill_start, done, launch;

   assign LINK.req = req_ff;
   assign LINK.we = we_ff;
   assign LINK.addr = addr_ff;
   assign LINK.wdata = wdata_ff;
   assign WB_ACK_O = ack_ff;
   assign WB_DAT_O = dat_ff;

   assign idx = WB_ADR_I[6:2];
   assign wb_take = WB_CYC_I && WB_STB_I && !ack_ff;
   assign dev_sel = !WB_ADR_I[7] && !idx[4];
   assign own_take = wb_take && !dev_sel;
   // partial writes to the device are acked but not forwarded
   assign fwd_take = wb_take && dev_sel && state_ff == ST_IDLE;
   assign fill_start = own_take && WB_WE_I && idx == WB_FILL
                       && state_ff == ST_IDLE && WB_DAT_I[CW-1:0] != '0;
   assign done = req_ff && LINK.ack;
   // one idle cycle between link requests
   assign launch = !req_ff && !LINK.ack;

   // ==========================================
   // link sequencer
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_ff <= ST_IDLE;
         req_ff <= 1'b0;
         we_ff <= 1'b0;
         addr_ff <= '0;
         wdata_ff <= '0;
         fill_k_ff <= '0;
         fill_n_ff <= '0;
      end else if (CE) begin
         case (state_ff)
            ST_IDLE: begin
               if (fill_start) begin
                  fill_k_ff <= WB_DAT_I[CW-1:0];
                  fill_n_ff <= '0; // RL4
                  state_ff <= ST_FILL_DAT;
               end else if (fwd_take && (!WB_WE_I || WB_SEL_I == 4'hF)) begin
                  req_ff <= 1'b1;
                  we_ff <= WB_WE_I;
                  addr_ff <= idx[RW-1:0];
                  wdata_ff <= WB_DAT_I;
                  state_ff <= ST_FWD;
               end
            end
            ST_FWD: begin
               if (done) begin
                  req_ff <= 1'b0;
                  state_ff <= ST_IDLE;
               end
            end
            ST_FILL_DAT: begin
               if (done) begin
                  req_ff <= 1'b0;
                  state_ff <= ST_FILL_CMD;
               end else if (launch) begin
                  req_ff <= 1'b1;
                  we_ff <= 1'b1;
                  addr_ff <= REG_DATA;
                  wdata_ff <= DW'(fill_n_ff); // RL4
               end
            end
            ST_FILL_CMD: begin
               if (done) begin
                  req_ff <= 1'b0;
                  state_ff <= ST_FILL_RDY;
               end else if (launch) begin
                  req_ff <= 1'b1;
                  we_ff <= 1'b1;
                  addr_ff <= REG_CMD;
                  wdata_ff <= (DW'(TYPE_FREE_TABLE) << CMD_TYPE_LSB)
                              | (32'h1 << CMD_WRITE_BIT); // RL3
               end
            end
            ST_FILL_RDY: begin
               if (done) begin
                  req_ff <= 1'b0;
                  // wait for ready before the next handle
                  if (LINK.rdata[0]) begin
                     fill_n_ff <= fill_n_ff + 1'b1;
                     state_ff <= (fill_n_ff + 1'b1 == fill_k_ff)
                                 ? ST_IDLE : ST_FILL_DAT; // RL4
                  end
               end else if (launch) begin
                  req_ff <= 1'b1;
                  we_ff <= 1'b0;
                  addr_ff <= REG_READY;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
               req_ff <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================
   // wishbone answer
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_ff <= 1'b0;
         dat_ff <= '0;
      end else if (CE) begin
         ack_ff <= own_take || (fwd_take && WB_WE_I && WB_SEL_I != 4'hF)
                   || (state_ff == ST_FWD && done);
         if (state_ff == ST_FWD && done) begin
            dat_ff <= we_ff ? '0 : LINK.rdata;
         end else if (own_take) begin
            dat_ff <= (idx == WB_STAT) ? (DW'(state_ff != ST_IDLE)
                      | (DW'(fill_n_ff) << ST_MC_LSB)) : '0;
         end else if (wb_take) begin
            dat_ff <= '0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/fbm_chk.sv */
// link protocol checker for the buffer manager register path
`default_nettype none
module fbm_chk (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic req,
   input wire logic we,
   input wire logic [fbm_pkg::RW-1:0] addr,
   input wire logic [fbm_pkg::DW-1:0] wdata,
   input wire logic [fbm_pkg::DW-1:0] rdata,
   input wire logic ack
);
   timeunit 1ns;
   timeprecision 1ps;
   import fbm_pkg::*;
   // ==========================================
   // link handshake
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   sequence s_take;
      req && !ack;
   endsequence
   sequence s_done;
      ack ##1 (!ack && !req);
   endsequence
   sequence s_push;
      s_take ##0 (we && addr == REG_CMD);
   endsequence
   a_take_answer: assert property (s_take |=> s_done)
      else $error("link request not answered");
   a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
      else $error("link ack without request");
   a_hold_req: assert property (s_take |=> $stable({we, addr, wdata}))
      else $error("link request changed before ack");
   a_rdata_hold: assert property (
      !(req && !we && !ack) |=> $stable(rdata))
      else $error("read data moved without a read");
   a_unknown_zero: assert property (
      s_take ##0 (!we && addr > REG_STATUS) |=> rdata == '0)
      else $error("unknown register read not zero");
   // ==========================================
   // pool fill sequence
   a_cmd_type: assert property (
      s_push |-> wdata[3:0] == TYPE_FREE_TABLE && wdata[CMD_WRITE_BIT])
      else $error("fill command has wrong type");
   a_cmd_poll: assert property (
      s_push |=> ##[2:8] (req && !we && addr == REG_READY))
      else $error("fill command not followed by ready poll");
   a_fill_value: assert property (
      s_take ##0 (we && addr == REG_DATA) |-> wdata[DW-1:HW] == '0)
      else $error("fill handle out of range");
endmodule
`default_nettype wire

/* File: sim/frame_buffer_manager_test.sv */
// self-checking bench for both ends of the buffer manager
`default_nettype none
module frame_buffer_manager_test;
   timeunit 1ns;
   timeprecision 1ps;
   import fbm_pkg::*;
   typedef struct {
      logic [7:0] a;
      logic w;
      logic [31:0] d;
      logic [31:0] e;
   } fbm_row_t;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, wwe = 0, rel = 0, ack;
   logic [7:0] adr = '0;
   logic [31:0] wd = '0, dout, r, tqw;
   logic [1:0] rq = '0, mc = '0, rxa;
   logic [1:0][3:0] rp = '0;
   logic [9:0] rh = '0, hnd;
   logic [23:0] aad, tqa, tqb, mlb, vlb, vmb, vmn;
   logic [11:0] blk;
   logic [4:0] msb;
   logic drop, ven, lerr;
   int num_errors = 0, checks = 0;
   fbm_row_t rows [8] = '{'{8'h10, 1, 2, 0}, '{8'h0C, 1, 3, 0},
      '{8'h14, 1, 1, 0}, '{8'h18, 1, 128, 0}, '{8'h0C, 0, 0, 3},
      '{8'h2C, 0, 0, 0}, '{8'h30, 0, 0, 0}, '{8'h80, 0, 0, 0}};
   fbm_if fbm_if_inst ();
   fbm_dev fbm_dev_inst (.MCLK(clk), .ARST_N(rst_n), .CE(1'b1),
      .LINK(fbm_if_inst.dev), .RX_REQ(rq), .RX_PORT(rp), .RX_MCAST(mc),
      .RX_ACK(rxa), .RX_DROP(drop), .ALLOC_HANDLE(hnd), .ALLOC_ADDR(aad),
      .REL_VALID(rel), .REL_HANDLE(rh), .PORT_BLOCKED(blk),
      .TXQ_SEL(6'h01), .TXQ_IDX(10'h002), .TXQ_ADDR(tqa), .TXQ_WORD(tqw),
      .TXQ_BASE(tqb), .MAIL_BASE(mlb), .VLAN_BASE(vlb), .VMAC_BASE(vmb),
      .VMAC_BYTES(vmn), .VLAN_EN(ven), .SRAM_ADDR_MSB(msb), .LAYOUT_ERR(lerr));
   fbm_ctl fbm_ctl_inst (.MCLK(clk), .ARST_N(rst_n), .CE(1'b1),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wwe), .WB_ADR_I(adr),
      .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(dout), .WB_ACK_O(ack),
      .LINK(fbm_if_inst.ctl));
   fbm_chk fbm_chk_inst (.MCLK(clk), .ARST_N(rst_n),
      .req(fbm_if_inst.req), .we(fbm_if_inst.we), .addr(fbm_if_inst.addr),
      .wdata(fbm_if_inst.wdata), .rdata(fbm_if_inst.rdata),
      .ack(fbm_if_inst.ack));
   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // request held until the rising edge that samples ack, released there
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      wwe <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (ack !== 1'b1);
      r = dout;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic rx(input logic [3:0] p, input logic m);
      @(posedge clk);
      rq[0] <= 1;
      rp[0] <= p;
      mc[0] <= m;
      do @(posedge clk); while (rxa[0] !== 1'b1);
      rq[0] <= 0;
   endtask
   task automatic end_sim;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========================================
   // stimulus
   initial forever #2.5 clk = ~clk;
   initial begin
      #100us;
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clk);
      chk({ven, msb}, 32'h0000_0012);
      rst_n <= 1;
      foreach (rows[i]) begin
         wb(rows[i].a, rows[i].w, rows[i].d);
         if (!rows[i].w) chk(r, rows[i].e);
      end
      rx(4'h3, 0);
      chk({drop, hnd}, 32'h0000_0400);
      wb(8'h40, 1, 32'h0000_0080);
      repeat (1000) begin
         wb(8'h44, 0, 0);
         if (r[0] === 1'b0) break;
      end
      chk(r, 32'h0080_0000);
      for (int i = 0; i < 5; i++) begin
         rx(4'h3, 0);
         chk({drop, hnd}, i < 4 ? 32'(i) : 32'h0000_0400);
         if (i < 4) chk(aad, 32'(i * 1536));
      end
      chk(blk, 12'h008);
      rx(4'h0, 1);
      chk({drop, hnd}, 32'h0000_0004);
      @(posedge clk);
      chk(tqw, 32'h0000_0004);
      rx(4'h0, 1);
      chk({drop, hnd}, 32'h0000_0400);
      wb(8'h2C, 0, 0);
      chk(r, 32'h0001_007B);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         rel <= 1;
         rh <= 10'(i == 3 ? 4 : i);
      end
      @(posedge clk);
      rel <= 0;
      repeat (2) @(posedge clk);
      chk(blk, 12'h000);
      wb(8'h2C, 0, 0);
      chk(r, 32'h0000_007F);
      chk(tqb, 32'h0003_0000);
      chk(mlb, 32'h0003_1800);
      chk(tqa, 32'h0003_0208);
      chk({vlb, ven, lerr, msb}, 32'h0000_0012);
      wb(8'h24, 0, 0);
      chk(r, 32'h8003_1800);
      wb(8'h28, 0, 0);
      chk(r, 32'h8003_1800);
      wb(8'h28, 0, 0);
      chk(r, 32'h0000_0000);
      // managed, two banks of large parts; tables past the mail region
      wb(8'h20, 1, 32'h0000_0083);
      wb(8'h1C, 1, 32'h0001_1007);
      chk({ven, lerr, msb}, 32'h0000_0054);
      chk(vlb, 32'h0003_8000);
      chk(vmb, 32'h0004_0000);
      chk(vmn, 32'h0000_8000);
      wb(8'h1C, 1, 32'h0003_1007);
      chk(lerr, 32'h0000_0001);
      // mid-run reset empties the pool again
      rst_n <= 0;
      @(posedge clk);
      rst_n <= 1;
      wb(8'h2C, 0, 0);
      chk(r, 32'h0000_0000);
      end_sim();
   end
endmodule
`default_nettype wire
